/* aux_pwm_regs.vh */
// Register offsets, field layout, reset values and timing constants.
`ifndef AUX_PWM_REGS_VH
`define AUX_PWM_REGS_VH

// Register offsets on the management register port.
`define REG_PART_IDENTITY        8'h3E
`define REG_AUX_SWITCHING_FREQ   8'h3F

// Frequency register fields.
`define AUX_FREQ_SEL_MSB         5
`define AUX_FREQ_SEL_LSB         0
`define AUX_FREQ_RSVD_MSB        7
`define AUX_FREQ_RSVD_LSB        6

// Reset value of the frequency register (lowest frequency).
`define AUX_FREQ_RESET           8'h00

// Reset value of the period in force; it matches selector code zero.
`define AUX_PERIOD_RESET         12'h801

// Identity byte; the value is arbitrary and only names this block.
`define PART_IDENTITY_DEFAULT    8'h5A

// Highest listed selector code; codes above it reuse its period.
`define AUX_FREQ_LAST_CODE       6'h36

// Reference clock rate in kHz and period counter width.
`define REF_CLK_KHZ              100000
`define AUX_PERIOD_WIDTH         12

// Value read back from an unmapped offset.
`define REG_UNMAPPED_VALUE       8'h00

`endif

/* aux_period_lookup.v */
// Selector code to auxiliary PWM period length lookup.
`timescale 1ns/1ps
`include "aux_pwm_regs.vh"

module aux_period_lookup (
  input  wire [5:0]                     freqCode,     // Six-bit frequency selector.
  output wire [`AUX_PERIOD_WIDTH-1:0]   periodCycles  // Period length in ref_clk cycles.
);

  // Each entry is REF_CLK_KHZ divided by the listed frequency, rounded to
  // the nearest whole cycle, so the longest period belongs to code zero
  // and the table falls strictly as the code rises to 6'h36.
  function [`AUX_PERIOD_WIDTH-1:0] periodOf;
    input [5:0] code;
    begin
      case (code)
        6'h00: periodOf = 12'h0801;
        6'h01: periodOf = 12'h07C0;
        6'h02: periodOf = 12'h0783;
        6'h03: periodOf = 12'h0743;
        6'h04: periodOf = 12'h0700;
        6'h05: periodOf = 12'h06BF;
        6'h06: periodOf = 12'h0680;
        6'h07: periodOf = 12'h0640;
        6'h08: periodOf = 12'h0600;
        6'h09: periodOf = 12'h05C1;
        6'h0A: periodOf = 12'h0580;
        6'h0B: periodOf = 12'h0540;
        6'h0C: periodOf = 12'h0500;
        6'h0D: periodOf = 12'h04C1;
        6'h0E: periodOf = 12'h0480;
        6'h0F: periodOf = 12'h0440;
        6'h10: periodOf = 12'h0401;
        6'h11: periodOf = 12'h03E0;
        6'h12: periodOf = 12'h03C1;
        6'h13: periodOf = 12'h03A1;
        6'h14: periodOf = 12'h0380;
        6'h15: periodOf = 12'h0360;
        6'h16: periodOf = 12'h0340;
        6'h17: periodOf = 12'h0320;
        6'h18: periodOf = 12'h0300;
        6'h19: periodOf = 12'h02E0;
        6'h1A: periodOf = 12'h02C0;
        6'h1B: periodOf = 12'h02A0;
        6'h1C: periodOf = 12'h0280;
        6'h1D: periodOf = 12'h0260;
        6'h1E: periodOf = 12'h0240;
        6'h1F: periodOf = 12'h0220;
        6'h20: periodOf = 12'h0200;
        6'h21: periodOf = 12'h01F0;
        6'h22: periodOf = 12'h01E0;
        6'h23: periodOf = 12'h01D0;
        6'h24: periodOf = 12'h01C0;
        6'h25: periodOf = 12'h01B0;
        6'h26: periodOf = 12'h01A0;
        6'h27: periodOf = 12'h0190;
        6'h28: periodOf = 12'h0181;
        6'h29: periodOf = 12'h0171;
        6'h2A: periodOf = 12'h0160;
        6'h2B: periodOf = 12'h0151;
        6'h2C: periodOf = 12'h0141;
        6'h2D: periodOf = 12'h0131;
        6'h2E: periodOf = 12'h0120;
        6'h2F: periodOf = 12'h0110;
        6'h30: periodOf = 12'h0100;
        6'h31: periodOf = 12'h00F0;
        6'h32: periodOf = 12'h00E0;
        6'h33: periodOf = 12'h00D0;
        6'h34: periodOf = 12'h00C0;
        6'h35: periodOf = 12'h00B0;
        // Unlisted codes stay at the fastest listed frequency.
        default: periodOf = 12'h00A0;
      endcase
    end
  endfunction

  // The lookup is pure decode; the caller registers the result.
  assign periodCycles = periodOf(freqCode);

endmodule

/* aux_pwm_frequency_select.v */
// Identity register, auxiliary frequency register and auxiliary PWM generator.
//
// Notes on behaviour
// - Eight-bit read-only identity register for software.
// - Identity is a constant, unchanged by writes.
// - Six-bit field picks aux frequency from table.
// - Aux output runs its own period and edges.
`timescale 1ns/1ps
`include "aux_pwm_regs.vh"

module aux_pwm_frequency_select #(
  // Identity byte; the default is arbitrary.
  parameter [7:0] PART_IDENTITY = `PART_IDENTITY_DEFAULT
) (
  input  wire                           ref_clk,            // 100 MHz clock.
  input  wire                           rst_n,              // Asynchronous reset.
  input  wire                           clkEn,              // Low freezes all state.
  input  wire [7:0]                     regAddr,            // Register offset.
  input  wire [7:0]                     regWrData,          // Write data byte.
  input  wire                           regWrEn,            // Write strobe.
  input  wire                           regRdEn,            // Read strobe.
  input  wire                           referenceEdge,      // Shared timing reference pulse.
  input  wire [`AUX_PERIOD_WIDTH-1:0]   auxRiseDelay,       // Aux rising edge, in cycles.
  input  wire [`AUX_PERIOD_WIDTH-1:0]   auxFallDelay,       // Aux falling edge, in cycles.
  output reg  [7:0]                     regRdData,          // Read data byte.
  output reg                            regRdValid,         // Read data valid pulse.
  output reg                            auxiliaryPwmOutput, // Gate drive for aux switch.
  output reg                            auxCycleStart       // Pulse at each aux period start.
);

  // Generator states, one-hot.
  localparam [1:0] ST_ALIGN = 2'b01;  // Waiting for the reference edge.
  localparam [1:0] ST_RUN   = 2'b10;  // Counting periods freely.

  // Software-visible frequency register, reserved bits included.
  reg  [7:0]                   freqReg_q;
  reg  [7:0]                   freqReg_d;
  // Generator state and its next value.
  reg  [1:0]                   state_q;
  reg  [1:0]                   state_d;
  // Position inside the current aux period.
  reg  [`AUX_PERIOD_WIDTH-1:0] periodCnt_q;
  reg  [`AUX_PERIOD_WIDTH-1:0] periodCnt_d;
  // Period length in force for the current period.
  reg  [`AUX_PERIOD_WIDTH-1:0] activePeriod_q;
  reg  [`AUX_PERIOD_WIDTH-1:0] activePeriod_d;
  // Next values of the registered outputs.
  reg  [7:0]                   regRdData_d;
  reg                          pwmOut_d;
  reg                          cycleStart_d;
  // Period length that the current selector code asks for.
  wire [`AUX_PERIOD_WIDTH-1:0] selectedPeriod;
  // Decoded register hits.
  wire                         hitIdentity;
  wire                         hitFreq;
  // Last count of the active period.
  wire                         periodEnd;

  // Only the six selector bits reach the table, so the reserved bits
  // can hold any value without moving the output frequency.
  aux_period_lookup periodTable (
    .freqCode     (freqReg_q[`AUX_FREQ_SEL_MSB:`AUX_FREQ_SEL_LSB]),
    .periodCycles (selectedPeriod)
  );

  // Register decode against the documented offsets.
  assign hitIdentity = (regAddr == `REG_PART_IDENTITY);
  assign hitFreq     = (regAddr == `REG_AUX_SWITCHING_FREQ);

  // The counter runs from zero to one below the period length.
  assign periodEnd = (periodCnt_q == (activePeriod_q - 12'h001));

  // Register writes. The identity offset has no storage behind it,
  // so a write there is dropped and the identity cannot change.
  always @*
  begin
    freqReg_d = freqReg_q;
    if (regWrEn && hitFreq)
    begin
      // All eight bits are stored; the upper two are reserved.
      freqReg_d = regWrData;
    end
  end

  // Read data mux. Unmapped offsets return a fixed value.
  always @*
  begin
    regRdData_d = regRdData;
    if (regRdEn)
    begin
      if (hitIdentity)
      begin
        // Hard-wired constant, never from a flip-flop that can be written.
        regRdData_d = PART_IDENTITY;
      end
      else if (hitFreq)
      begin
        regRdData_d = freqReg_q;
      end
      else
      begin
        regRdData_d = `REG_UNMAPPED_VALUE;
      end
    end
  end

  // Generator sequencing. After reset, and after every change of the
  // selector, the aux counter waits for the shared reference edge so
  // that its period starts in a known place against the other outputs.
  // A frequency change ends the current period at once, even mid-pulse;
  // the drive is forced low until the reference edge starts the new
  // period, so a pulse in progress can be cut into a runt at the gate driver.
  always @*
  begin
    state_d        = state_q;
    periodCnt_d    = periodCnt_q;
    activePeriod_d = activePeriod_q;
    case (state_q)
      ST_ALIGN:
      begin
        // Hold the counter at zero until the reference pulse arrives.
        periodCnt_d = {`AUX_PERIOD_WIDTH{1'b0}};
        if (referenceEdge)
        begin
          activePeriod_d = selectedPeriod;
          state_d        = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (regWrEn && hitFreq &&
            (regWrData[`AUX_FREQ_SEL_MSB:`AUX_FREQ_SEL_LSB] !=
             freqReg_q[`AUX_FREQ_SEL_MSB:`AUX_FREQ_SEL_LSB]))
        begin
          // New selector code: realign before running again.
          state_d     = ST_ALIGN;
          periodCnt_d = {`AUX_PERIOD_WIDTH{1'b0}};
        end
        else if (periodEnd)
        begin
          // Wrap and pick up the period for the next cycle.
          periodCnt_d    = {`AUX_PERIOD_WIDTH{1'b0}};
          activePeriod_d = selectedPeriod;
        end
        else
        begin
          periodCnt_d = periodCnt_q + 12'h001;
        end
      end
      default:
      begin
        // Illegal code: recover through alignment.
        state_d     = ST_ALIGN;
        periodCnt_d = {`AUX_PERIOD_WIDTH{1'b0}};
      end
    endcase
  end

  // Output decode from the next count, so the registered drive lines
  // up with the count it belongs to. The aux edges are compared with
  // the aux counter only, independent of the main PWM period.
  always @*
  begin
    pwmOut_d     = 1'b0;
    cycleStart_d = 1'b0;
    if (state_d == ST_RUN)
    begin
      pwmOut_d = (periodCnt_d >= auxRiseDelay) && (periodCnt_d < auxFallDelay);
      cycleStart_d = (periodCnt_d == {`AUX_PERIOD_WIDTH{1'b0}});
    end
  end

  // Register file and read port flip-flops.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freqReg_q  <= `AUX_FREQ_RESET;
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end
    else if (clkEn)
    begin
      freqReg_q  <= freqReg_d;
      regRdData  <= regRdData_d;
      // Read answers exactly one cycle after the strobe.
      regRdValid <= regRdEn;
    end
  end

  // Generator flip-flops. The drive output resets low so the switch
  // stays off until the first aligned period.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q            <= ST_ALIGN;
      periodCnt_q        <= {`AUX_PERIOD_WIDTH{1'b0}};
      activePeriod_q     <= `AUX_PERIOD_RESET;
      auxiliaryPwmOutput <= 1'b0;
      auxCycleStart      <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q            <= state_d;
      periodCnt_q        <= periodCnt_d;
      activePeriod_q     <= activePeriod_d;
      auxiliaryPwmOutput <= pwmOut_d;
      auxCycleStart      <= cycleStart_d;
    end
  end

endmodule

/* gate_driver_model.sv */
// Gate driver stand-in that measures each on-time of the gate drive.
`timescale 1ns/1ps
module gate_driver_model (
  input  wire        ref_clk,  // Bench clock.
  input  wire        rst_n,    // Asynchronous reset, active low.
  input  wire        gateIn,   // Gate drive from the block.
  output reg  [11:0] onWidth   // Length of the last complete on-time.
);
  reg [11:0] onCnt_q; // Cycles spent high in the current pulse.
  // The driver only receives, so it has no way to push back on the block.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      onCnt_q <= 12'h000;
      onWidth <= 12'h000;
    end
    else if (gateIn)
      onCnt_q <= onCnt_q + 12'h001;
    else if (onCnt_q != 12'h000)
    begin
      onWidth <= onCnt_q;
      onCnt_q <= 12'h000;
    end
  end
endmodule

/* aux_pwm_frequency_select_chk.sv */
// Concurrent checks on the ports of the auxiliary frequency block.
`timescale 1ns/1ps
module aux_pwm_frequency_select_chk #(
  parameter [7:0] PART_IDENTITY = 8'h00
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        clkEn,
  input wire [7:0]  regAddr,
  input wire [7:0]  regWrData,
  input wire        regWrEn,
  input wire        regRdEn,
  input wire        referenceEdge,
  input wire [11:0] auxRiseDelay,
  input wire [11:0] auxFallDelay,
  input wire [7:0]  regRdData,
  input wire        regRdValid,
  input wire        auxiliaryPwmOutput,
  input wire        auxCycleStart
);
  reg  [7:0]  shadow_q; // Frequency register as software wrote it.
  reg         run_q;    // High once the generator has aligned.
  reg  [11:0] gap_q;    // Cycles since the last period start.
  wire        rd  = regRdEn && clkEn;
  wire        wrF = regWrEn && clkEn && regAddr == 8'h3F;
  wire        chg = wrF && regWrData[5:0] != shadow_q[5:0];
  wire [11:0] expPer;
  // Only codes with a known period are checked; others give zero and are skipped.
  function [11:0] perOf(input [5:0] s);
    case (s)
      6'h00:   perOf = 12'h801;
      6'h07:   perOf = 12'h640;
      6'h17:   perOf = 12'h320;
      default: perOf = (s >= 6'h36) ? 12'h0A0 : 12'h000;
    endcase
  endfunction
  assign expPer = perOf(shadow_q[5:0]);
  // Tracking freezes with the clock enable, just as the block does.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_q <= 8'h00;
      run_q    <= 1'b0;
      gap_q    <= 12'h000;
    end
    else if (clkEn)
    begin
      if (wrF)
        shadow_q <= regWrData;
      run_q <= chg ? 1'b0 : (run_q | auxCycleStart);
      gap_q <= auxCycleStart ? 12'h001 : gap_q + 12'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rd_answer: assert property (rd |=> regRdValid) else $error("read not answered");
  a_valid_cause: assert property (regRdValid && $past(clkEn) |-> $past(rd))
    else $error("stray valid");
  a_ident_fixed: assert property (rd && regAddr == 8'h3E |=> regRdData == PART_IDENTITY)
    else $error("identity byte wrong");
  a_unmapped_zero: assert property (rd && regAddr != 8'h3E && regAddr != 8'h3F
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  a_freq_readback: assert property (rd && regAddr == 8'h3F |=> regRdData == $past(shadow_q))
    else $error("frequency readback wrong");
  a_data_holds: assert property (!rd |=> $stable(regRdData)) else $error("data moved");
  // A realign may restart the period soon after a start, so the spacing
  // is only checked between two starts of one uninterrupted run.
  a_start_pulse: assert property (auxCycleStart && clkEn |=> !auxCycleStart)
    else $error("start pulse too long");
  a_start_gap: assert property (auxCycleStart && run_q |-> gap_q >= 12'h0A0)
    else $error("start pulses too close");
  a_ref_start: assert property (referenceEdge && clkEn && !run_q && !auxCycleStart
    |=> auxCycleStart) else $error("no start after reference");
  a_idle_low: assert property (!run_q && !auxCycleStart |-> !auxiliaryPwmOutput)
    else $error("output high while unaligned");
  a_period_exact: assert property (auxCycleStart && run_q && expPer != 12'h000
    |-> gap_q == expPer) else $error("period length wrong");
  a_freeze_all: assert property (!clkEn |=> $stable(auxiliaryPwmOutput)
    && $stable(auxCycleStart)) else $error("state moved while frozen");
  c_ident: cover property (rd && regAddr == 8'h3E);
  c_period: cover property (auxCycleStart && run_q);
  c_realign: cover property (chg);
endmodule

/* aux_pwm_frequency_select_tb.sv */
// Self-checking bench for the auxiliary frequency block.
`timescale 1ns/1ps
module aux_pwm_frequency_select_tb;
  localparam [7:0] IDENT = 8'hC7; // Arbitrary identity value for this run.
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         clkEn = 1'b1;
  reg  [7:0]  regAddr = 8'h00;
  reg  [7:0]  regWrData = 8'h00;
  reg         regWrEn = 1'b0;
  reg         regRdEn = 1'b0;
  reg         referenceEdge = 1'b0;
  reg  [11:0] auxRiseDelay = 12'h00A;
  reg  [11:0] auxFallDelay = 12'h03C;
  wire [7:0]  regRdData;
  wire        regRdValid;
  wire        auxiliaryPwmOutput;
  wire        auxCycleStart;
  wire [11:0] onWidth;
  integer     failures = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     seed = 32'h95eeaa09;
  integer     i;
  integer     n;
  reg  [7:0]  r;
  reg  [7:0]  rdQ [$];   // Expected read bytes in issue order.
  reg  [5:0]  codes [0:4];
  reg  [11:0] pers [0:4];
  aux_pwm_frequency_select #(.PART_IDENTITY(IDENT)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .referenceEdge(referenceEdge), .auxRiseDelay(auxRiseDelay),
    .auxFallDelay(auxFallDelay), .regRdData(regRdData), .regRdValid(regRdValid),
    .auxiliaryPwmOutput(auxiliaryPwmOutput), .auxCycleStart(auxCycleStart));
  gate_driver_model drv_u (.ref_clk(ref_clk), .rst_n(rst_n), .gateIn(auxiliaryPwmOutput),
    .onWidth(onWidth));
  task chk(input string nm, input [11:0] e, input [11:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task test_done;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // Strobes rise and fall on falling edges so the block samples settled values.
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(negedge ref_clk);
    regAddr = a;
    rdQ.push_back(e);
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
  end
  endtask
  task refp;
  begin
    @(negedge ref_clk);
    referenceEdge = 1'b1;
    @(negedge ref_clk);
    referenceEdge = 1'b0;
  end
  endtask
  // Waits for one period start, then counts cycles to the next one.
  task per(input [11:0] e);
  begin
    n = 0;
    while (auxCycleStart !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    n = 0;
    @(negedge ref_clk);
    while (auxCycleStart !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk("period", e, n + 1);
  end
  endtask
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Read answers are matched against the oldest note; a hang ends the run as a mismatch.
  always @(negedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles > 60000)
    begin
      failures = failures + 1;
      test_done;
    end
    else if (regRdValid === 1'b1)
    begin
      if (rdQ.size() == 0)
        chk("unexpected read", 12'h000, 12'h001);
      else
        chk("read data", {4'h0, rdQ.pop_front()}, {4'h0, regRdData});
    end
  end
  initial
  begin
    codes = '{6'h00, 6'h07, 6'h17, 6'h36, 6'h3F};
    pers = '{12'h801, 12'h640, 12'h320, 12'h0A0, 12'h0A0};
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(8'h3E, IDENT);
    wr(8'h3E, 8'hFF);
    rd(8'h3E, IDENT);
    rd(8'h3F, 8'h00);
    rd(8'h10, 8'h00);
    r = $random(seed);
    wr(8'h3F, r);
    rd(8'h3F, r);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(8'h3F, {2'b01, codes[i]});
      refp;
      per(pers[i]);
      refp;
      per(pers[i]);
      wr(8'h3F, {2'b10, codes[i]});
      per(pers[i]);
      chk("on width", 12'h032, onWidth);
    end
    @(negedge ref_clk);
    clkEn = 1'b0;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    repeat (6) @(negedge ref_clk);
    clkEn = 1'b1;
    per(12'h0A0);
    test_done;
  end
endmodule
bind aux_pwm_frequency_select aux_pwm_frequency_select_chk #(.PART_IDENTITY(PART_IDENTITY))
  chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .referenceEdge(referenceEdge),
  .auxRiseDelay(auxRiseDelay), .auxFallDelay(auxFallDelay), .regRdData(regRdData),
  .regRdValid(regRdValid), .auxiliaryPwmOutput(auxiliaryPwmOutput),
  .auxCycleStart(auxCycleStart));
